// *** hw/fmul_defines.svh ***
/*
 Constants for the fractional multiply unit: instruction fields,
 opcode values, flag positions and saturation values.
 Assumes a 32-bit instruction word and a 32-bit control register.
*/
`ifndef FMUL_DEFINES_SVH
`define FMUL_DEFINES_SVH

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define MAJOR_HI 31
`define MAJOR_LO 26
`define SUBOP_HI 10
`define SUBOP_LO 6
`define FUNC_HI 5
`define FUNC_LO 0

// ----------------------------------------
// Opcode values
// ----------------------------------------
`define EXTENSION_MAJOR_OPCODE 6'b01_1111
`define SUBOP_PAIR_RND 5'b1_1111
`define FUNC_PAIR_RND 6'b01_0000
`define SUBOP_QUAD_RND 5'b1_1111
`define FUNC_QUAD_RND 6'b01_0100
`define SUBOP_WORD_RND 5'b0_1111
`define FUNC_WORD_RND 6'b01_1000
`define SUBOP_PAIR_TRUNC 5'b1_1110
`define FUNC_PAIR_TRUNC 6'b01_0000

// ----------------------------------------
// Control register and arithmetic constants
// ----------------------------------------
`define OUFLAG_SAT_BIT 21
`define Q15_MIN 16'h8000
`define Q15_MAX 16'h7FFF
`define Q15_RND 32'h0000_8000
`define Q31_MIN 32'h8000_0000
`define Q31_MAX 32'h7FFF_FFFF
`define Q31_RND 64'h0000_0000_8000_0000

`endif

// *** hw/fmul_pkg.sv ***
/*
 Types shared by the fractional multiply unit.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fmul_pkg;

	// Gray coded along the order in which the ops are listed
	typedef enum logic [2:0]
	{
		OP_NONE = 3'b000,
		OP_PAIR_RND = 3'b001,
		OP_QUAD_RND = 3'b011,
		OP_WORD_RND = 3'b010,
		OP_PAIR_TRUNC = 3'b110
	} op_e;

	typedef logic [15:0] half_t;

endpackage

// *** hw/q15_lane.sv ***
/*
 One Q15 fractional multiply lane, with optional rounding and
 saturation of the single overflowing operand pair.
 Assumes it is purely combinational and used from a clocked wrapper.
*/
`timescale 1ns/1ns
`include "fmul_defines.svh"

module q15_lane
	import fmul_pkg::*;
(
	input wire half_t a, // Lane of first source
	input wire half_t b, // Lane of second source
	input wire logic rnd, // Add the rounding constant
	output half_t res, // Lane result
	output logic sat // Lane saturated
);

	logic signed [31:0] prod;
	logic [31:0] shifted;
	logic [31:0] sum;

	assign prod = $signed(a) * $signed(b);
	assign shifted = {prod[30:0], 1'b0};
	// Rounding adds half an output lsb before truncation
	assign sum = shifted + (rnd ? `Q15_RND : 32'h0000_0000);
	// Only -1 times -1 overflows; it bypasses rounding
	assign sat = (a == `Q15_MIN) && (b == `Q15_MIN);
	// Truncating mode simply drops the low half
	assign res = sat ? `Q15_MAX : sum[31:16];

endmodule

// *** hw/frac_mul_unit.sv ***
/*
 Fractional multiply execution unit: two-lane and four-lane Q15
 rounding multiply, Q31 rounding multiply and two-lane Q15 truncating
 multiply, with one register stage to the write-back side.
 Assumes the pipeline steers only instructions meant for this unit,
 supplies the current control register value with each issue, and
 writes back the returned value when the write enable is high.
*/
`timescale 1ns/1ns
`include "fmul_defines.svh"

module frac_mul_unit
	import fmul_pkg::*;
#(
	parameter int LANES = 4
)
(
	input wire logic clk, // Processor clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic issue_valid, // Instruction issued to this unit
	input wire logic [31:0] instr, // Instruction word
	input wire logic [63:0] first_source_register, // First source value
	input wire logic [63:0] second_source_register, // Second source value
	input wire logic ext_enabled, // Extension enabled by status
	input wire logic [31:0] ctl_in, // Current control register value
	output logic done_valid, // Result stage holds an issued op
	output logic [63:0] rd_data, // Destination value
	output logic rd_we, // Write destination register
	output logic [31:0] ctl_out, // Control register value to write back
	output logic ctl_we, // Write control register
	output logic acc0_clobber, // Accumulator zero left undefined
	output logic exc_reserved, // Reserved-instruction exception
	output logic exc_ext_disabled // Extension-disabled exception
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic op_e decode_op(input logic [31:0] iw);
		logic [5:0] major;
		logic [4:0] subop;
		logic [5:0] func;
		major = iw[`MAJOR_HI:`MAJOR_LO];
		subop = iw[`SUBOP_HI:`SUBOP_LO];
		func = iw[`FUNC_HI:`FUNC_LO];
		decode_op = OP_NONE;
		if (major != `EXTENSION_MAJOR_OPCODE)
		begin
			decode_op = OP_NONE;
		end
		else if (subop == `SUBOP_PAIR_RND && func == `FUNC_PAIR_RND)
		begin
			decode_op = OP_PAIR_RND;
		end
		else if (subop == `SUBOP_QUAD_RND && func == `FUNC_QUAD_RND)
		begin
			decode_op = OP_QUAD_RND;
		end
		else if (subop == `SUBOP_WORD_RND && func == `FUNC_WORD_RND)
		begin
			decode_op = OP_WORD_RND;
		end
		else if (subop == `SUBOP_PAIR_TRUNC && func == `FUNC_PAIR_TRUNC)
		begin
			decode_op = OP_PAIR_TRUNC;
		end
	endfunction

	op_e op;
	logic known;
	logic accept;
	logic reject_reserved;
	logic reject_disabled;

	assign op = decode_op(instr);
	assign known = (op != OP_NONE);
	// Exceptions look only at the instruction and the enable
	assign reject_reserved = issue_valid && !known;
	assign reject_disabled = issue_valid && known && !ext_enabled;
	assign accept = issue_valid && known && ext_enabled;

	// ----------------------------------------
	// Q15 lanes
	// ----------------------------------------
	// Pair ops must ignore saturation in the upper lanes, which still compute
	function automatic logic [LANES-1:0] counted_lanes(input op_e o);
		counted_lanes = {LANES{1'b0}};
		case (o)
			OP_PAIR_RND, OP_PAIR_TRUNC:
			begin
				counted_lanes[1:0] = 2'b11;
			end
			OP_QUAD_RND:
			begin
				counted_lanes = {LANES{1'b1}};
			end
			default:
			begin
				counted_lanes = {LANES{1'b0}};
			end
		endcase
	endfunction

	half_t lane_res [LANES];
	logic [LANES-1:0] lane_sat;
	logic [LANES-1:0] lane_counted;
	logic lane_rnd;

	// Only the truncating pair skips the rounding constant
	assign lane_rnd = (op != OP_PAIR_TRUNC);
	assign lane_counted = counted_lanes(op);

	// All lanes always compute; the op decides which ones count
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			q15_lane u_lane
			(
				.a(first_source_register[16*g +: 16]),
				.b(second_source_register[16*g +: 16]),
				.rnd(lane_rnd),
				.res(lane_res[g]),
				.sat(lane_sat[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Q31 word
	// ----------------------------------------
	logic signed [63:0] word_prod;
	logic [63:0] word_shifted;
	logic [63:0] word_sum;
	logic word_sat;
	logic [31:0] word_res;

	assign word_prod = $signed(first_source_register[31:0]) * $signed(second_source_register[31:0]);
	assign word_shifted = {word_prod[62:0], 1'b0};
	// One at bit 31 rounds before the low word is dropped
	assign word_sum = word_shifted + `Q31_RND;
	assign word_sat = (first_source_register[31:0] == `Q31_MIN) && (second_source_register[31:0] == `Q31_MIN);
	// The single overflowing pair clips and skips rounding
	assign word_res = word_sat ? `Q31_MAX : word_sum[63:32];

	// ----------------------------------------
	// Result select
	// ----------------------------------------
	// Sign extension of a 32-bit result into the upper word, shared by three ops
	function automatic logic [63:0] sext32(input logic [31:0] v);
		sext32 = {{32{v[31]}}, v};
	endfunction

	logic [63:0] result;
	logic sat_any;

	always_comb
	begin
		result = 64'h0000_0000_0000_0000;
		sat_any = 1'b0;
		case (op)
			OP_PAIR_RND:
			begin
				// Upper lane sign fills the high word
				result = sext32({lane_res[1], lane_res[0]});
				sat_any = |(lane_sat & lane_counted);
			end
			OP_QUAD_RND:
			begin
				// Each lane lands in place, no extension
				result = {lane_res[3], lane_res[2], lane_res[1], lane_res[0]};
				sat_any = |(lane_sat & lane_counted);
			end
			OP_WORD_RND:
			begin
				result = sext32(word_res);
				sat_any = word_sat;
			end
			OP_PAIR_TRUNC:
			begin
				result = sext32({lane_res[1], lane_res[0]});
				sat_any = |(lane_sat & lane_counted);
			end
			default:
			begin
				result = 64'h0000_0000_0000_0000;
				sat_any = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Flag update
	// ----------------------------------------
	logic [31:0] ctl_next;
	logic [31:0] sat_mask;

	assign sat_mask = 32'h0000_0001 << `OUFLAG_SAT_BIT;
	// OR only: never clears, other bits pass unchanged
	assign ctl_next = ctl_in | (sat_any ? sat_mask : 32'h0000_0000);

	// ----------------------------------------
	// Result stage registers
	// ----------------------------------------
	logic done_valid_q;
	logic [63:0] rd_data_q;
	logic rd_we_q;
	logic [31:0] ctl_out_q;
	logic ctl_we_q;
	logic acc0_clobber_q;
	logic exc_reserved_q;
	logic exc_ext_disabled_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			done_valid_q <= 1'b0;
		end
		else
		begin
			done_valid_q <= issue_valid;
		end
	end

	// Destination write follows acceptance only
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_we_q <= 1'b0;
		end
		else
		begin
			rd_we_q <= accept;
		end
	end

	// Data held when idle so the bus does not toggle needlessly
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_data_q <= 64'h0000_0000_0000_0000;
		end
		else if (accept)
		begin
			rd_data_q <= result;
		end
	end

	// Write back only on saturation; the pipeline keeps the register itself
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctl_we_q <= 1'b0;
		end
		else
		begin
			ctl_we_q <= accept && sat_any;
		end
	end

	// Merged value tracks every accepted op, saturating or not
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctl_out_q <= 32'h0000_0000;
		end
		else if (accept)
		begin
			ctl_out_q <= ctl_next;
		end
	end

	// Accumulators are never written here; zero is only flagged
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			acc0_clobber_q <= 1'b0;
		end
		else
		begin
			acc0_clobber_q <= accept;
		end
	end

	// Reserved takes priority over disabled
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			exc_reserved_q <= 1'b0;
		end
		else
		begin
			exc_reserved_q <= reject_reserved;
		end
	end

	// Disabled only for a recognised op, never from operand values
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			exc_ext_disabled_q <= 1'b0;
		end
		else
		begin
			exc_ext_disabled_q <= reject_disabled;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign done_valid = done_valid_q;
	assign rd_data = rd_data_q;
	assign rd_we = rd_we_q;
	assign ctl_out = ctl_out_q;
	assign ctl_we = ctl_we_q;
	assign acc0_clobber = acc0_clobber_q;
	assign exc_reserved = exc_reserved_q;
	assign exc_ext_disabled = exc_ext_disabled_q;

endmodule

// *** testbench/ctl_reg_stage.sv ***
/*
 Pipeline stage model that keeps the control register for the unit.
 Assumes the unit returns a full register value with a write strobe.
*/
`timescale 1ns/1ns

module ctl_reg_stage
#(
	parameter logic [31:0] INIT = 32'h0000_a5a5
)
(
	input wire logic clk, // Clock
	input wire logic arst_n, // Reset
	input wire logic ctl_we, // Write strobe
	input wire logic [31:0] ctl_out, // Value from unit
	output logic [31:0] ctl_in, // Value to unit
	output logic [31:0] ctl_q // Held register
);
	// Bypass, so an issue right behind a saturating op still sees the flag
	assign ctl_in = ctl_we ? ctl_out : ctl_q;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ctl_q <= INIT;
		else if (ctl_we)
			ctl_q <= ctl_out;
	end
endmodule

// *** testbench/frac_mul_unit_chk.sv ***
/*
 Assertion checker for the fractional multiply unit.
 Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ns

module frac_mul_unit_chk
	import fmul_pkg::*;
#(
	parameter int LANES = 4
)
(
	input wire logic clk, // Clock
	input wire logic arst_n, // Reset
	input wire logic issue_valid, // Issue
	input wire logic [31:0] instr, // Word
	input wire logic [63:0] first_source_register, // Source 1
	input wire logic [63:0] second_source_register, // Source 2
	input wire logic ext_enabled, // Enable
	input wire logic [31:0] ctl_in, // Flags in
	input wire logic done_valid, // Done
	input wire logic [63:0] rd_data, // Result
	input wire logic rd_we, // Result write
	input wire logic [31:0] ctl_out, // Flags out
	input wire logic ctl_we, // Flags write
	input wire logic acc0_clobber, // Acc 0 lost
	input wire logic exc_reserved, // Reserved
	input wire logic exc_ext_disabled // Disabled
);
	logic [31:0] a, b;
	logic m, pr, qd, wd, tr, kn;

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	assign a = first_source_register[31:0];
	assign b = second_source_register[31:0];
	assign m = issue_valid && instr[31:26] == 6'h1f;
	assign pr = m && instr[10:0] == 11'h7d0;
	assign qd = m && instr[10:0] == 11'h7d4;
	assign wd = m && instr[10:0] == 11'h3d8;
	assign tr = m && instr[10:0] == 11'h790;
	assign kn = pr || qd || wd || tr;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_answer_once: assert property (done_valid |-> $onehot({rd_we, exc_reserved, exc_ext_disabled}))
		else $error("answer count wrong");
	chk_clobber_tracks: assert property (acc0_clobber == rd_we)
		else $error("clobber mismatch");
	chk_disabled_exc: assert property (kn && !ext_enabled |=> exc_ext_disabled && !ctl_we)
		else $error("disabled not refused");
	chk_known_taken: assert property (kn && ext_enabled |=> rd_we)
		else $error("known op not taken");
	chk_pair_sat: assert property (pr && ext_enabled && a[15:0] == 16'h8000 && b[15:0] == 16'h8000
		|=> rd_data[15:0] == 16'h7fff && ctl_we) else $error("pair saturation wrong");
	chk_word_sat: assert property (wd && ext_enabled && a == 32'h8000_0000 && b == 32'h8000_0000
		|=> rd_data == 64'h0000_0000_7fff_ffff && ctl_we) else $error("word saturation wrong");
	chk_trunc_sat: assert property (tr && ext_enabled && a[31:16] == 16'h8000 && b[31:16] == 16'h8000
		|=> rd_data[63:16] == 48'h0000_0000_7fff && ctl_we) else $error("trunc saturation wrong");
	chk_sign_fill: assert property (rd_we && !$past(qd) |-> rd_data[63:32] == {32{rd_data[31]}})
		else $error("sign fill wrong");
	chk_flag_sticky: assert property (rd_we |-> ctl_out == ($past(ctl_in) | {10'h000, ctl_we, 21'h00_0000}))
		else $error("flag merge wrong");
	chk_refused_hold: assert property (exc_reserved || exc_ext_disabled |-> $stable(rd_data) && !ctl_we)
		else $error("refused op changed state");

	cover property (pr && ext_enabled ##1 ctl_we);
	cover property (wd && ext_enabled ##1 ctl_we);
	cover property (exc_ext_disabled);
endmodule

bind frac_mul_unit frac_mul_unit_chk #(.LANES(LANES)) chk_u (.clk(clk), .arst_n(arst_n), .issue_valid(issue_valid),
	.instr(instr), .first_source_register(first_source_register), .second_source_register(second_source_register),
	.ext_enabled(ext_enabled), .ctl_in(ctl_in), .done_valid(done_valid), .rd_data(rd_data), .rd_we(rd_we),
	.ctl_out(ctl_out), .ctl_we(ctl_we), .acc0_clobber(acc0_clobber), .exc_reserved(exc_reserved),
	.exc_ext_disabled(exc_ext_disabled));

// *** testbench/fractional_multiply_round_saturate_tb.sv ***
/*
 Self-checking bench for the fractional multiply unit.
 Assumes the control register is kept by the pipeline stage model.
*/
`timescale 1ns/1ns

module fractional_multiply_round_saturate_tb
	import fmul_pkg::*;
;
	localparam logic [31:0] OPS [4] = '{32'h7c00_07d0, 32'h7c00_07d4, 32'h7c00_03d8, 32'h7c00_0790};
	localparam logic [63:0] S = 64'h8000_8000_0001_7fff;
	localparam logic [63:0] T = 64'h8000_8000_ffff_7fff;
	localparam logic [63:0] M = 64'h8000_8000_8000_8000;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic iv = 1'b0;
	logic en = 1'b0;
	logic [31:0] instr = 32'h0000_0000;
	logic [63:0] src_a = 64'h0000_0000_0000_0000;
	logic [63:0] src_b = 64'h0000_0000_0000_0000;
	logic [63:0] last_rd = 64'h0000_0000_0000_0000;
	logic [31:0] last_ctl = 32'h0000_0000;
	logic [31:0] ctl_in, ctl_out, ctl_q;
	logic [63:0] rd_data;
	logic done_valid, rd_we, ctl_we, acc0_clobber, exc_reserved, exc_ext_disabled;
	int fails = 0;
	int total_checks = 0;

	initial forever #50 clk = ~clk;

	frac_mul_unit #(.LANES(4)) dut_u (.clk(clk), .arst_n(arst_n), .issue_valid(iv), .instr(instr),
		.first_source_register(src_a), .second_source_register(src_b), .ext_enabled(en), .ctl_in(ctl_in),
		.done_valid(done_valid), .rd_data(rd_data), .rd_we(rd_we), .ctl_out(ctl_out), .ctl_we(ctl_we),
		.acc0_clobber(acc0_clobber), .exc_reserved(exc_reserved), .exc_ext_disabled(exc_ext_disabled));
	ctl_reg_stage pipe_u (.clk(clk), .arst_n(arst_n), .ctl_we(ctl_we), .ctl_out(ctl_out), .ctl_in(ctl_in),
		.ctl_q(ctl_q));

	// ----------------------------------------
	// Reference arithmetic
	// ----------------------------------------
	function automatic logic [16:0] q15(input logic [15:0] a, input logic [15:0] b, input logic r);
		logic signed [31:0] p;
		if (a == 16'h8000 && b == 16'h8000)
			return {1'b1, 16'h7fff};
		p = $signed(a) * $signed(b);
		p = (p <<< 1) + (r ? 32'h0000_8000 : 32'h0000_0000);
		return {1'b0, p[31:16]};
	endfunction

	function automatic logic [32:0] q31(input logic [31:0] a, input logic [31:0] b);
		logic signed [63:0] p;
		if (a == 32'h8000_0000 && b == 32'h8000_0000)
			return {1'b1, 32'h7fff_ffff};
		p = $signed(a) * $signed(b);
		p = (p <<< 1) + 64'h0000_0000_8000_0000;
		return {1'b0, p[63:32]};
	endfunction

	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (!ok)
		begin
			fails++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask

	// Issues back to back: each op's result is judged one cycle after it is presented, before the next op is driven
	task automatic op(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b, input logic e);
		logic [16:0] l0, l1, l2, l3;
		logic [32:0] w;
		logic [63:0] x;
		logic [31:0] c;
		logic s, k;
		// Sub-op bit 6 is set for rounding and clear for truncating
		l0 = q15(a[15:0], b[15:0], i[6]);
		l1 = q15(a[31:16], b[31:16], i[6]);
		l2 = q15(a[47:32], b[47:32], i[6]);
		l3 = q15(a[63:48], b[63:48], i[6]);
		w = q31(a[31:0], b[31:0]);
		k = 1'b1;
		c = ctl_in;
		case (i)
			OPS[0], OPS[3]: {s, x} = {l0[16] | l1[16], {32{l1[15]}}, l1[15:0], l0[15:0]};
			OPS[1]: {s, x} = {l0[16] | l1[16] | l2[16] | l3[16], l3[15:0], l2[15:0], l1[15:0], l0[15:0]};
			OPS[2]: {s, x} = {w[32], {32{w[31]}}, w[31:0]};
			default: {k, s, x} = {2'b00, last_rd};
		endcase
		iv = 1'b1;
		instr = i;
		src_a = a;
		src_b = b;
		en = e;
		@(posedge clk);
		#1;
		last_rd = (k & e) ? x : last_rd;
		last_ctl = (k & e) ? (c | {10'h000, s, 21'h00_0000}) : last_ctl;
		s = s & k & e;
		chk(done_valid === 1'b1 && rd_we === (k & e) && acc0_clobber === (k & e), "accept strobes");
		chk(exc_reserved === !k && exc_ext_disabled === (k & !e), "exception strobes");
		chk(rd_data === last_rd, "destination value");
		chk(ctl_we === s && ctl_out === last_ctl, "control write-back");
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_refuse;
		for (int n = 0; n < 4; n++)
			op(OPS[n], M, M, 1'b0);
		op(32'h7c00_07d1, M, M, 1'b1);
		op(32'h7c00_0794, M, M, 1'b1);
		op(32'h7800_07d4, M, M, 1'b1);
	endtask

	task automatic t_pair_rnd;
		op(OPS[0], S, T, 1'b1);
		op(OPS[0], M, 64'h1234_5678_4000_8000, 1'b1);
	endtask

	task automatic t_quad;
		op(OPS[1], 64'h7fff_0001_c000_0100, 64'h0001_ffff_c000_00ff, 1'b1);
		op(OPS[1], S, T, 1'b1);
	endtask

	task automatic t_pair_trunc;
		op(OPS[3], S, T, 1'b1);
		op(OPS[3], M, 64'h0000_0000_8000_0003, 1'b1);
	endtask

	task automatic t_word;
		op(OPS[2], 64'hdead_beef_4000_0000, 64'h1234_5678_c000_0001, 1'b1);
		op(OPS[2], 64'h0000_0000_0000_0001, 64'h0000_0000_ffff_ffff, 1'b1);
		op(OPS[2], 64'hdead_beef_8000_0000, 64'h1234_5678_8000_0000, 1'b1);
	endtask

	task automatic t_idle;
		iv = 1'b0;
		@(posedge clk);
		#1;
		chk(done_valid === 1'b0 && rd_we === 1'b0 && exc_reserved === 1'b0, "strobe too long");
		chk(ctl_q === 32'h0020_a5a5, "flag not kept");
	endtask

	task automatic results;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		arst_n = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		arst_n = 1'b1;
		t_refuse();
		t_pair_rnd();
		t_quad();
		t_pair_trunc();
		t_word();
		t_idle();
		results();
	end
endmodule
